// ---- charge_seq_pkg.sv ----
package charge_seq_pkg;

    // ========================================================
    // timing
    // ========================================================
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned TERM_FILTER_US  = 1000;
    localparam int unsigned TERM_FILTER_CYC =
        (CLK_HZ / 1_000_000) * TERM_FILTER_US;
    localparam int unsigned SAFETY_HOURS    = 4;
    localparam int unsigned SYNC_STAGES     = 2;

    // ========================================================
    // charge current command
    // ========================================================
    localparam logic [1:0] CUR_OFF   = 2'h0;
    localparam logic [1:0] CUR_TENTH = 2'h1;
    localparam logic [1:0] CUR_FULL  = 2'h2;

    // ========================================================
    // APB register map (byte addresses)
    // ========================================================
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_TIMER  = 8'h08;
    localparam int unsigned CTRL_TIMER_DIS_BIT = 0;
    localparam int unsigned CTRL_CHG_DIS_BIT   = 1;
    localparam logic [1:0] CTRL_RESET  = 2'h0;

    // ========================================================
    // states
    // ========================================================
    typedef enum logic [7:0] {
        ST_SHUTDOWN = 8'h01,
        ST_PRECOND  = 8'h02,
        ST_CC       = 8'h04,
        ST_CV       = 8'h08,
        ST_COMPLETE = 8'h10,
        ST_FAULT    = 8'h20,
        ST_STANDBY  = 8'h40,
        ST_QUALIFY  = 8'h80
    } state_type;

endpackage : charge_seq_pkg

// ---- flag_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module flag_sync
    import charge_seq_pkg::*;
#(
    parameter int unsigned WIDTH = 10
)
(
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    initial
    begin
        if (WIDTH < 1) $error("flag_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule : flag_sync
`default_nettype wire

// ---- charge_cycle_sequencer.sv ----
// Contract
// - low battery at cycle start selects preconditioning
// - preconditioning commands one tenth of fast charge current
// - battery above precondition threshold moves to constant current
// - constant current commands full programmed fast charge current
// - stay in constant current until regulation voltage reached, then CV
// - safety timer cleared on every entry to constant current
// - timer expiry before regulation voltage flags timer fault, ends cycle
// - timer fault held until battery-present goes false
// - after removal clears fault, standby until battery present again
// - terminate in CV only after termination flag holds full filter time
// - timer expiry also terminates; period is build option, can disable
// - on termination current command latched off, enter complete
// - in complete, below recharge threshold starts new cycle
// - die over-temperature suspends charging until hysteresis flag clears
// - thermistor out of window stops charge and freezes timer
// - input droop flag requests reduced charge current
// - input current limit flag requests reduced charge current only
// - system current is never limited by this logic
// - without input present, system runs from battery
// - status encoding: charging L/Z, complete Z/L, fault L/L
// - timer_on_low low enables safety timer, high disables it
// - charge enable low disables charger, high enables it
// - shutdown until lockout passed and input above battery
`timescale 1ns/1ps
`default_nettype none
module charge_cycle_sequencer
    import charge_seq_pkg::*;
#(
    parameter int unsigned FILTER_CYCLES = TERM_FILTER_CYC,
    parameter longint unsigned TIMER_CYCLES =
        longint'(CLK_HZ) * 64'd3600 * longint'(SAFETY_HOURS),
    parameter int unsigned TIMER_W = 40
)
(
    input  wire logic        clk_sys_i,
    input  wire logic        reset_n_i,
    input  wire logic        bat_below_precond_i,
    input  wire logic        bat_at_vreg_i,
    input  wire logic        bat_below_recharge_i,
    input  wire logic        term_current_low_i,
    input  wire logic        die_over_temp_i,
    input  wire logic        die_cooled_i,
    input  wire logic        battery_thermistor_sense_out_of_window_i,
    input  wire logic        input_droop_throttle_i,
    input  wire logic        input_current_throttle_i,
    input  wire logic        input_ok_i,
    input  wire logic        battery_present_i,
    input  wire logic        timer_on_low_i,
    input  wire logic        charge_enable_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [1:0]  charge_current_cmd_o,
    output logic             current_reduce_o,
    output logic             system_from_battery_o,
    output logic             status_out_a_o,
    output logic             status_out_a_oe_o,
    output logic             status_out_b_o,
    output logic             status_out_b_oe_o
);

    initial
    begin
        if (FILTER_CYCLES < 1) $error("FILTER_CYCLES must be at least 1");
        if (TIMER_W < 32 || TIMER_W > 63) $error("TIMER_W must be 32 to 63");
        if (TIMER_CYCLES < 1 || TIMER_CYCLES >= (64'd1 << TIMER_W))
            $error("TIMER_CYCLES does not fit TIMER_W");
    end

    // ========================================================
    // reset release and flag synchronisation
    // ========================================================
    logic [1:0] rst_pipe_q;
    logic       rst_n;

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rst_pipe_q <= 2'h0;
        else
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
    assign rst_n = rst_pipe_q[1];

    logic [12:0] raw_flags;
    logic [12:0] flags;
    assign raw_flags = {bat_below_precond_i, bat_at_vreg_i,
                        bat_below_recharge_i, term_current_low_i,
                        die_over_temp_i, die_cooled_i, battery_thermistor_sense_out_of_window_i,
                        input_droop_throttle_i, input_current_throttle_i,
                        input_ok_i, battery_present_i, timer_on_low_i,
                        charge_enable_i};

    flag_sync #(.WIDTH(13)) flag_sync_i (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n),
        .async_i   (raw_flags),
        .sync_o    (flags)
    );

    logic low_bat, at_vreg, below_rech, term_low, die_hot, die_cool;
    logic battery_thermistor_sense_bad, droop, ilimit, in_ok, bat_ok, timer_on_low, chg_en;
    assign {low_bat, at_vreg, below_rech, term_low, die_hot, die_cool,
            battery_thermistor_sense_bad, droop, ilimit, in_ok, bat_ok, timer_on_low,
            chg_en} = flags;

    // ========================================================
    // registers
    // ========================================================
    logic [1:0] ctrl_q;
    logic       timer_en;
    logic       charger_en;
    assign timer_en   = !timer_on_low && !ctrl_q[CTRL_TIMER_DIS_BIT];
    assign charger_en = chg_en && !ctrl_q[CTRL_CHG_DIS_BIT];

    // ========================================================
    // thermal suspend
    // ========================================================
    logic die_susp_q;
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            die_susp_q <= 1'b0;
        else if (die_hot)
            die_susp_q <= 1'b1;
        else if (die_cool)
            die_susp_q <= 1'b0;
    end

    logic suspend;
    assign suspend = die_susp_q || battery_thermistor_sense_bad;

    // ========================================================
    // state machine
    // ========================================================
    state_type state_q, state_d;
    logic [TIMER_W-1:0] timer_q;
    logic [31:0]        filt_q;
    logic               timer_exp;
    logic               term_done;
    logic               charging;

    assign timer_exp = timer_en && (timer_q >= TIMER_W'(TIMER_CYCLES));
    assign term_done = (filt_q >= FILTER_CYCLES);
    assign charging  = (state_q == ST_PRECOND) || (state_q == ST_CC) ||
                       (state_q == ST_CV);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_SHUTDOWN:
                if (in_ok && charger_en)
                    state_d = ST_QUALIFY;
            ST_QUALIFY:
                if (bat_ok)
                    state_d = low_bat ? ST_PRECOND : ST_CC;
            ST_PRECOND:
                if (timer_exp)
                    state_d = ST_FAULT;
                else if (!low_bat && !suspend)
                    state_d = ST_CC;
            ST_CC:
                if (timer_exp)
                    state_d = ST_FAULT;
                else if (at_vreg)
                    state_d = ST_CV;
            ST_CV:
                if (term_done || timer_exp)
                    state_d = ST_COMPLETE;
            ST_COMPLETE:
                if (below_rech)
                    state_d = ST_QUALIFY;
            ST_FAULT:
                if (!bat_ok)
                    state_d = ST_STANDBY;
            ST_STANDBY:
                if (bat_ok)
                    state_d = ST_QUALIFY;
            default:
                state_d = ST_SHUTDOWN;
        endcase
        if (!in_ok || !charger_en)
            state_d = ST_SHUTDOWN;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= ST_SHUTDOWN;
        else
            state_q <= state_d;
    end

    // ========================================================
    // safety timer
    // ========================================================
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            timer_q <= '0;
        else if (state_d == ST_CC && state_q != ST_CC)
            timer_q <= '0;
        else if (state_q == ST_QUALIFY)
            timer_q <= '0;
        else if (charging && timer_en && !suspend && !timer_exp)
            timer_q <= timer_q + TIMER_W'(1);
    end

    // ========================================================
    // termination filter
    // ========================================================
    // any gap restarts the count so load transients shorter than FILTER_CYCLES never end a cycle
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            filt_q <= '0;
        else if (state_q != ST_CV || !term_low || suspend)
            filt_q <= '0;
        else if (!term_done)
            filt_q <= filt_q + 32'h1;
    end

    // ========================================================
    // outputs
    // ========================================================
    logic [1:0] cur_q;
    logic       reduce_q;
    logic       a_on_q, b_on_q, from_bat_q;

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            cur_q <= CUR_OFF;
        else if (suspend || state_d == ST_COMPLETE)
            cur_q <= CUR_OFF;
        else if (state_d == ST_PRECOND)
            cur_q <= CUR_TENTH;
        else if (state_d == ST_CC || state_d == ST_CV)
            cur_q <= CUR_FULL;
        else
            cur_q <= CUR_OFF;
    end

    // only charge current is throttled; system path is untouched
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            reduce_q <= 1'b0;
        else
            reduce_q <= droop || ilimit;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            from_bat_q <= 1'b1;
        else
            from_bat_q <= !in_ok;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            a_on_q <= 1'b0;
            b_on_q <= 1'b0;
        end
        else
        begin
            a_on_q <= (state_d inside {ST_PRECOND, ST_CC, ST_CV, ST_FAULT})
                      || (battery_thermistor_sense_bad && state_d != ST_SHUTDOWN);
            b_on_q <= (state_d inside {ST_COMPLETE, ST_FAULT})
                      || (battery_thermistor_sense_bad && state_d != ST_SHUTDOWN);
        end
    end

    assign charge_current_cmd_o  = cur_q;
    assign current_reduce_o      = reduce_q;
    assign system_from_battery_o = from_bat_q;
    assign status_out_a_o        = 1'b0;
    assign status_out_a_oe_o     = a_on_q;
    assign status_out_b_o        = 1'b0;
    assign status_out_b_oe_o     = b_on_q;

    // ========================================================
    // APB slave, zero wait states
    // ========================================================
    logic acc;
    assign acc     = psel && penable;
    assign pready  = 1'b1;
    assign pslverr = acc && !(paddr == ADDR_CTRL || paddr == ADDR_STATUS ||
                              paddr == ADDR_TIMER);

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_q <= CTRL_RESET;
        else if (acc && pwrite && paddr == ADDR_CTRL)
            ctrl_q <= pwdata[1:0];
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                ADDR_CTRL:   prdata <= {30'h0, ctrl_q};
                ADDR_STATUS: prdata <= {22'h0, timer_en, charger_en,
                                        state_q};
                ADDR_TIMER:  prdata <= timer_q[31:0];
                default:     prdata <= 32'h0;
            endcase
        end
    end

    // ========================================================
    // checks
    // ========================================================
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n);

    sequence s_cc_entry;
        state_q != ST_CC ##1 state_q == ST_CC;
    endsequence

    AST_PRECOND_SELECT: assert property (
        state_q == ST_QUALIFY && bat_ok && low_bat && in_ok && charger_en
        |=> state_q == ST_PRECOND) else $error("precondition not selected");
    AST_PRECOND_TENTH: assert property (
        state_q == ST_PRECOND && !$past(suspend)
        |-> cur_q == CUR_TENTH) else $error("precondition current wrong");
    AST_CC_TO_CV: assert property (
        state_q == ST_CC && at_vreg && !timer_exp && in_ok && charger_en
        |=> state_q == ST_CV) else $error("no CV entry");
    AST_TIMER_CLEAR: assert property (
        s_cc_entry |-> timer_q == '0) else $error("timer not cleared");
    AST_FAULT_HOLD: assert property (
        state_q == ST_FAULT && bat_ok && in_ok && charger_en
        |=> state_q == ST_FAULT) else $error("fault released early");
    AST_FILTER: assert property (
        $rose(state_q == ST_COMPLETE) && !$past(timer_exp)
        |-> $past(filt_q) >= FILTER_CYCLES) else $error("early stop");
    AST_CURRENT_OFF: assert property (
        state_q == ST_COMPLETE |-> cur_q == CUR_OFF) else $error("current on");
    AST_BATTERY_THERMISTOR_SENSE_FREEZE: assert property (
        battery_thermistor_sense_bad && charging
        |=> $stable(timer_q)) else $error("timer ran during fault");
    AST_STATUS_FAULT: assert property (
        state_q == ST_FAULT ##1 state_q == ST_FAULT
        |-> status_out_a_oe_o && status_out_b_oe_o) else $error("no fault");

endmodule : charge_cycle_sequencer
`default_nettype wire

// ---- charge_battery_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ========================================================
// cell and comparator model on the far side of the sequencer
// ========================================================
module charge_battery_model
    import charge_seq_pkg::*;
#(
    parameter int unsigned PRE_LVL  = 20,
    parameter int unsigned VREG_LVL = 80,
    parameter int unsigned RCH_LVL  = 70,
    parameter int unsigned TAPER    = 100
)
(
    input  wire logic       clk_sys_i,
    input  wire logic [1:0] cur_cmd_i,
    input  wire logic       load_i,
    input  wire logic       set_i,
    input  wire logic [7:0] set_val_i,
    input  wire logic       glitch_i,
    output logic            bat_below_precond_o,
    output logic            bat_at_vreg_o,
    output logic            bat_below_recharge_o,
    output logic            term_current_low_o
);
    logic [7:0] volt_q;
    logic [3:0] slow_q;
    logic [7:0] taper_q;
    logic       gain;

    // a tenth of the current charges the cell ten times slower
    assign gain = (cur_cmd_i == CUR_FULL) ||
                  ((cur_cmd_i == CUR_TENTH) && (slow_q == 4'h0));

    always_ff @(posedge clk_sys_i)
    begin
        // the divider must start known or a tenth current never charges
        if (set_i)
            slow_q <= 4'h0;
        else
            slow_q <= (slow_q == 4'h9) ? 4'h0 : slow_q + 4'h1;
        if (set_i)
            volt_q <= set_val_i;
        else if (gain && !load_i && (volt_q < VREG_LVL))
            volt_q <= volt_q + 8'h01;
        else if (!gain && load_i && (volt_q > 0))
            volt_q <= volt_q - 8'h01;
    end

    // current tapers only after the cell has sat at regulation a while
    always_ff @(posedge clk_sys_i)
    begin
        if (volt_q < VREG_LVL)
            taper_q <= 8'h00;
        else if (taper_q != 8'hFF)
            taper_q <= taper_q + 8'h01;
    end

    assign bat_below_precond_o  = (volt_q < PRE_LVL);
    assign bat_at_vreg_o        = (volt_q >= VREG_LVL);
    assign bat_below_recharge_o = (volt_q < RCH_LVL);
    // glitch_i models a transient load dip seen by the comparator
    assign term_current_low_o   = (taper_q >= TAPER) || glitch_i;
endmodule : charge_battery_model
`default_nettype wire

// ---- charge_cycle_sequencer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module charge_cycle_sequencer_test
    import charge_seq_pkg::*;
;
    logic        clk_sys_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        prec, vreg, rech, term;
    logic        die_hot = 0, die_cool = 1, battery_thermistor_sense_bad = 0;
    logic        droop = 0, iclim = 0, in_ok = 0, bat_in = 1;
    logic        tmr_off = 0, chg_en = 1, load = 0, set_v = 1, glitch = 0;
    logic [7:0]  set_val = 8'h00;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rm;
    logic        pready, pslverr, reduce, from_bat;
    logic        sa, sa_oe, sb, sb_oe;
    logic [1:0]  cmd;
    logic [5:0]  out_q[$], outm_q[$], ov, om;
    logic [32:0] rd_q[$], re;
    logic [31:0] rdm_q[$];
    int          errors = 0, checks = 0;
    event        snap;

    always #12.5 clk_sys_i = ~clk_sys_i;

    charge_battery_model charge_battery_model_i (.clk_sys_i(clk_sys_i),
        .cur_cmd_i(cmd), .load_i(load), .set_i(set_v), .set_val_i(set_val),
        .glitch_i(glitch), .bat_below_precond_o(prec), .bat_at_vreg_o(vreg),
        .bat_below_recharge_o(rech), .term_current_low_o(term));

    charge_cycle_sequencer #(.FILTER_CYCLES(20), .TIMER_CYCLES(64'd2000))
    charge_cycle_sequencer_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .bat_below_precond_i(prec), .bat_at_vreg_i(vreg),
        .bat_below_recharge_i(rech), .term_current_low_i(term),
        .die_over_temp_i(die_hot), .die_cooled_i(die_cool),
        .battery_thermistor_sense_out_of_window_i(battery_thermistor_sense_bad), .input_droop_throttle_i(droop),
        .input_current_throttle_i(iclim), .input_ok_i(in_ok),
        .battery_present_i(bat_in), .timer_on_low_i(tmr_off),
        .charge_enable_i(chg_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .charge_current_cmd_o(cmd),
        .current_reduce_o(reduce), .system_from_battery_o(from_bat),
        .status_out_a_o(sa), .status_out_a_oe_o(sa_oe),
        .status_out_b_o(sb), .status_out_b_oe_o(sb_oe));

    // ========================================================
    // shared tasks
    // ========================================================
    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task final_report();
        if (errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    task cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : cyc

    // outputs settle within sync latency plus two state steps
    task expect_out(input logic [5:0] v, input logic [5:0] m);
        cyc(8);
        #1;
        out_q.push_back(v);
        outm_q.push_back(m);
        ->snap;
        @(posedge clk_sys_i);
    endtask : expect_out

    // samples on the falling edge, then realigns to the rising edge
    task wait_cmd(input logic [1:0] c, input int lim);
        int i;
        i = 0;
        @(negedge clk_sys_i);
        while (i < lim && cmd !== c)
        begin
            @(negedge clk_sys_i);
            i++;
        end
        check("wait_cmd", {30'h0, cmd}, {30'h0, c});
        @(posedge clk_sys_i);
    endtask : wait_cmd

    task setv(input logic [7:0] v);
        set_val <= v;
        set_v   <= 1'b1;
        cyc(1);
        set_v   <= 1'b0;
    endtask : setv

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic [31:0] e, input logic [31:0] m, input logic err);
        @(posedge clk_sys_i);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        rd_q.push_back({err, e});
        rdm_q.push_back(m);
        @(posedge clk_sys_i);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do
            @(posedge clk_sys_i);
        while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // ========================================================
    // monitors
    // ========================================================
    always @(posedge clk_sys_i)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            re = rd_q.pop_front();
            rm = rdm_q.pop_front();
            check("prdata", prdata & rm, re[31:0]);
            check("pslverr", {31'h0, pslverr}, {31'h0, re[32]});
        end
    end

    always @(snap)
    begin
        ov = out_q.pop_front();
        om = outm_q.pop_front();
        check("outputs", {26'h0, {cmd, sa_oe, sb_oe, reduce, from_bat} & om},
              {26'h0, ov});
        check("status_level", {30'h0, sa, sb}, 32'h0);
    end

    initial
    begin
        #250000;
        errors++;
        final_report();
    end

    // ========================================================
    // main sequence
    // ========================================================
    initial
    begin
        void'($urandom(52));
        cyc(16);
        reset_n_i <= 1'b1;
        cyc(4);
        expect_out({CUR_OFF, 4'b0001}, 6'h3F);
        apb(0, ADDR_CTRL, 0, {30'h0, CTRL_RESET}, 32'h3, 0);
        setv(8'h05);
        in_ok <= 1'b1;
        expect_out({CUR_TENTH, 4'b1000}, 6'h3F);
        wait_cmd(CUR_FULL, 400);
        expect_out({CUR_FULL, 4'b1000}, 6'h3F);
        apb(0, ADDR_TIMER, 0, 0, 32'hFFFFFF00, 0);
        load <= 1'b1;
        setv(8'(40 + $urandom_range(30)));
        die_hot  <= 1'b1;
        die_cool <= 1'b0;
        expect_out({CUR_OFF, 4'b0}, 6'h30);
        die_hot  <= 1'b0;
        expect_out({CUR_OFF, 4'b0}, 6'h30);
        die_cool <= 1'b1;
        expect_out({CUR_FULL, 4'b0}, 6'h30);
        battery_thermistor_sense_bad <= 1'b1;
        expect_out({CUR_OFF, 4'b1100}, 6'h3F);
        battery_thermistor_sense_bad <= 1'b0;
        expect_out({CUR_FULL, 4'b1000}, 6'h3F);
        droop <= 1'b1;
        expect_out(6'h02, 6'h03);
        droop <= 1'b0;
        iclim <= 1'b1;
        expect_out(6'h02, 6'h03);
        iclim <= 1'b0;
        expect_out(6'h00, 6'h03);
        load <= 1'b0;
        setv(8'd60);
        cyc(30);
        apb(0, ADDR_STATUS, 0, {24'h0, ST_CV}, 32'hFF, 0);
        glitch <= 1'b1;
        cyc(1 + $urandom_range(14));
        glitch <= 1'b0;
        cyc(4);
        apb(0, ADDR_STATUS, 0, {24'h0, ST_CV}, 32'hFF, 0);
        wait_cmd(CUR_OFF, 300);
        expect_out({CUR_OFF, 4'b0100}, 6'h3F);
        load <= 1'b1;
        wait_cmd(CUR_FULL, 200);
        expect_out({CUR_FULL, 4'b1000}, 6'h3F);
        apb(0, ADDR_TIMER, 0, 0, 32'hFFFFFF00, 0);
        wait_cmd(CUR_OFF, 2300);
        load <= 1'b0;
        expect_out({CUR_OFF, 4'b1100}, 6'h3F);
        cyc(100);
        expect_out({CUR_OFF, 4'b1100}, 6'h3F);
        bat_in <= 1'b0;
        expect_out(6'h00, 6'h3F);
        apb(0, ADDR_STATUS, 0, {24'h0, ST_STANDBY}, 32'hFF, 0);
        bat_in <= 1'b1;
        load   <= 1'b1;
        expect_out({CUR_FULL, 4'b1000}, 6'h3F);
        tmr_off <= 1'b1;
        cyc(2600);
        expect_out({CUR_FULL, 4'b1000}, 6'h3F);
        apb(0, ADDR_STATUS, 0, {22'h1, ST_CC}, 32'h3FF, 0);
        tmr_off <= 1'b0;
        setv(8'd60);
        chg_en <= 1'b0;
        expect_out({CUR_OFF, 4'b0}, 6'h30);
        chg_en <= 1'b1;
        expect_out({CUR_FULL, 4'b0}, 6'h30);
        apb(1, ADDR_CTRL, 32'h2, 0, 0, 0);
        expect_out({CUR_OFF, 4'b0}, 6'h30);
        apb(0, ADDR_CTRL, 0, 32'h2, 32'h3, 0);
        apb(1, ADDR_CTRL, 32'h0, 0, 0, 0);
        expect_out({CUR_FULL, 4'b0}, 6'h30);
        // unmapped place: refused on both directions
        apb(1, 8'h0C, 32'hFFFF_FFFF, 0, 0, 1);
        apb(0, 8'h0C, 0, 0, 32'hFFFF_FFFF, 1);
        in_ok <= 1'b0;
        expect_out({CUR_OFF, 4'b0001}, 6'h31);
        final_report();
    end
endmodule : charge_cycle_sequencer_test
`default_nettype wire
